//--- wpf_full_flag.sv
`timescale 1ns/100ps
`default_nettype none
`include "wpf_map.svh"

module wpf_full_flag
    import wpf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    wpf_sel_if.flag sel,
    input wire logic [`WPF_NUM_QUEUES-1:0] queue_full_i,
    output logic full_flag_n_o,
    output logic full_flag_oe_o,
    output logic [`WPF_QUEUE_W-1:0] queue_o
);

    logic [`WPF_QUEUE_W-1:0] queue_reg;
    logic [`WPF_QUEUE_W-1:0] queue_next;
    logic own_reg;
    logic own_next;
    logic ff_reg;
    logic ff_next;

    always_comb begin
        queue_next = queue_reg;
        own_next = own_reg;
        if (sel.sel_take) begin
            queue_next = sel.sel_queue;
            own_next = sel.sel_mine;
        end
        // A queue number beyond this device's queues reads as full so no write is invited.
        if (queue_next[`WPF_QUEUE_MSB]) begin
            ff_next = 1'h0;
        end else begin
            ff_next = ~queue_full_i[queue_next[`WPF_QIDX_MSB:0]];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            queue_reg <= `WPF_QUEUE_RST;
            own_reg <= 1'h0;
            ff_reg <= 1'h0;
        end else begin
            queue_reg <= queue_next;
            own_reg <= own_next;
            ff_reg <= ff_next;
        end
    end

    assign full_flag_n_o = ff_reg;
    assign full_flag_oe_o = own_reg;
    assign queue_o = queue_reg;

endmodule : wpf_full_flag

`default_nettype wire

//--- wpf_map.svh
`ifndef WPF_MAP_SVH
`define WPF_MAP_SVH

// Write queue address: device select in the top bits, queue in the low bits.
`define WPF_WADDR_W 8
`define WPF_DEV_MSB 7
`define WPF_DEV_LSB 5
`define WPF_ID_W 3
`define WPF_QUEUE_W 5
`define WPF_QUEUE_MSB 4
`define WPF_QIDX_MSB 3
`define WPF_NUM_QUEUES 16
`define WPF_SECT_W 8
`define WPF_SECT_BIT 3
`define WPF_SECT1_MSB 7
`define WPF_SECT1_LSB 0
`define WPF_SECT2_MSB 15
`define WPF_SECT2_LSB 8

// Register port.
`define WPF_REG_AW 8
`define WPF_REG_DW 32
`define WPF_OFS_STATUS 8'h00
`define WPF_OFS_IRQ_STAT 8'h04
`define WPF_OFS_IRQ_MASK 8'h08

// Status register fields.
`define WPF_ST_MODE 0
`define WPF_ST_ID_LSB 1
`define WPF_ST_ID_MSB 3
`define WPF_ST_MASTER 4
`define WPF_ST_QUEUE_LSB 5
`define WPF_ST_QUEUE_MSB 9
`define WPF_ST_FF_OWN 10
`define WPF_ST_BUS_OE 11
`define WPF_ST_SEQ_LSB 12
`define WPF_ST_SEQ_MSB 15
`define WPF_ST_SECT 16

// Interrupt status and mask layout.
`define WPF_IRQ_W 3
`define WPF_IRQ_FULL 0
`define WPF_IRQ_LOOP 1
`define WPF_IRQ_STRB 2

// Reset values.
`define WPF_IRQ_RST 3'h0
`define WPF_ID_RST 3'h0
`define WPF_QUEUE_RST 5'h00
`define WPF_BUS_IDLE 8'hff
`define WPF_RDATA_RST 32'h0000_0000

`endif

//--- wpf_pkg.sv
package wpf_pkg;

    typedef enum logic [3:0] {
        WPF_POLL_START = 4'h1,
        WPF_POLL_IDLE = 4'h2,
        WPF_POLL_SECT1 = 4'h4,
        WPF_POLL_SECT2 = 4'h8
    } wpf_poll_state_t;

    typedef enum logic {
        WPF_MODE_DIRECT = 1'h0,
        WPF_MODE_POLLED = 1'h1
    } wpf_mode_t;

endpackage : wpf_pkg

//--- wpf_poll_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "wpf_map.svh"

module wpf_poll_seq
    import wpf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    wpf_sel_if.flag sel,
    input wire logic token_in_i,
    output wpf_poll_state_t state_o,
    output wpf_poll_state_t state_next_o
);

    wpf_poll_state_t state_reg;
    wpf_poll_state_t state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            WPF_POLL_START: begin
                // The master opens the loop on the first edge after reset.
                state_next = (sel.polled && sel.master) ? WPF_POLL_SECT1 : WPF_POLL_IDLE;
            end
            WPF_POLL_IDLE: begin
                if (sel.polled && token_in_i) begin
                    state_next = WPF_POLL_SECT1;
                end
            end
            WPF_POLL_SECT1: begin
                state_next = WPF_POLL_SECT2;
            end
            WPF_POLL_SECT2: begin
                // A single device sees its own token here and goes straight back to sector 1.
                state_next = token_in_i ? WPF_POLL_SECT1 : WPF_POLL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= WPF_POLL_START;
        end else begin
            state_reg <= state_next;
        end
    end

    assign state_o = state_reg;
    assign state_next_o = state_next;

endmodule : wpf_poll_seq

`default_nettype wire

//--- wpf_sel_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "wpf_map.svh"

interface wpf_sel_if;
    logic sel_take;
    logic [`WPF_QUEUE_W-1:0] sel_queue;
    logic sel_mine;
    logic polled;
    logic master;

    modport ctrl (
        output sel_take,
        output sel_queue,
        output sel_mine,
        output polled,
        output master
    );

    modport flag (
        input sel_take,
        input sel_queue,
        input sel_mine,
        input polled,
        input master
    );
endinterface : wpf_sel_if

`default_nettype wire

//--- wpf_token_peer.sv
`timescale 1ns/100ps
`default_nettype none

module wpf_token_peer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] delay_i,
    input wire logic token_i,
    output logic token_o
);
    // Stands in for the rest of the chain: a token that leaves comes back delay_i cycles later.
    logic [15:0] pipe_reg;
    logic [15:0] pipe_next;

    always_comb begin
        pipe_next = {pipe_reg[14:0], token_i};
        if (!rst_n_i) begin
            pipe_next = 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        pipe_reg <= pipe_next;
    end

    // Delay zero is the lone device with its token output wired straight back in.
    // In direct mode no token ever leaves, so the input stays low.
    assign token_o = (delay_i == 4'h0) ? token_i : pipe_reg[delay_i - 4'h1];
endmodule : wpf_token_peer

`default_nettype wire

//--- wpf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "wpf_map.svh"

module wpf_top
    import wpf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`WPF_WADDR_W-1:0] write_queue_address_bus_i,
    input wire logic write_address_enable_i,
    input wire logic [`WPF_NUM_QUEUES-1:0] queue_full_i,
    input wire logic [`WPF_NUM_QUEUES-1:0] queue_almost_full_i,
    input wire logic flag_mode_select_i,
    input wire logic [`WPF_ID_W-1:0] device_identity_pins_i,
    input wire logic master_device_i,
    input wire logic almost_full_bus_strobe_i,
    input wire logic serial_enable_output_n_i,
    input wire logic almost_full_token_in_i,
    input wire logic [`WPF_REG_AW-1:0] reg_addr_i,
    input wire logic [`WPF_REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic full_flag_n_o,
    output logic full_flag_oe_o,
    output logic [`WPF_SECT_W-1:0] almost_full_flag_bus_n_o,
    output logic almost_full_flag_bus_oe_o,
    output logic almost_full_bus_sync_o,
    output logic almost_full_token_out_o,
    output logic [`WPF_REG_DW-1:0] reg_rdata_o,
    output logic irq_o
);

    wpf_sel_if sel_bus ();

    // Configuration caught while reset is held; it must not move afterwards.
    wpf_mode_t mode_reg;
    wpf_mode_t mode_next;
    logic [`WPF_ID_W-1:0] id_reg;
    logic [`WPF_ID_W-1:0] id_next;
    logic master_reg;
    logic master_next;

    always_comb begin
        mode_next = mode_reg;
        id_next = id_reg;
        master_next = master_reg;
        if (!rst_n_i) begin
            mode_next = wpf_mode_t'(flag_mode_select_i);
            id_next = device_identity_pins_i;
            master_next = master_device_i;
        end
    end

    always_ff @(posedge clk_i) begin
        mode_reg <= mode_next;
        id_reg <= id_next;
        master_reg <= master_next;
    end

    logic polled;
    logic dev_match;

    always_comb begin
        polled = (mode_reg == WPF_MODE_POLLED);
        dev_match = (write_queue_address_bus_i[`WPF_DEV_MSB:`WPF_DEV_LSB] == id_reg);
        sel_bus.sel_take = write_address_enable_i;
        sel_bus.sel_queue = write_queue_address_bus_i[`WPF_QUEUE_MSB:0];
        sel_bus.sel_mine = dev_match;
        sel_bus.polled = polled;
        sel_bus.master = master_reg;
    end

    logic [`WPF_QUEUE_W-1:0] ff_queue;

    wpf_full_flag u_full_flag (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sel(sel_bus.flag),
        .queue_full_i(queue_full_i),
        .full_flag_n_o(full_flag_n_o),
        .full_flag_oe_o(full_flag_oe_o),
        .queue_o(ff_queue)
    );

    wpf_poll_state_t seq_state;
    wpf_poll_state_t seq_state_next;

    wpf_poll_seq u_poll_seq (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sel(sel_bus.flag),
        .token_in_i(almost_full_token_in_i),
        .state_o(seq_state),
        .state_next_o(seq_state_next)
    );

    // Direct-mode sector choice and the flag bus output stage.
    logic dir_own_reg;
    logic dir_own_next;
    logic dir_sect_reg;
    logic dir_sect_next;
    logic strobe_ok;
    logic strobe_bad;
    logic [`WPF_SECT_W-1:0] bus_reg;
    logic [`WPF_SECT_W-1:0] bus_next;
    logic bus_oe_reg;
    logic bus_oe_next;
    logic sync_reg;
    logic sync_next;
    logic token_reg;
    logic token_next;
    logic [`WPF_SECT_W-1:0] sect1_n;
    logic [`WPF_SECT_W-1:0] sect2_n;

    always_comb begin
        sect1_n = ~queue_almost_full_i[`WPF_SECT1_MSB:`WPF_SECT1_LSB];
        sect2_n = ~queue_almost_full_i[`WPF_SECT2_MSB:`WPF_SECT2_LSB];
        // A strobe during programming or in polled mode is ignored and reported.
        strobe_ok = almost_full_bus_strobe_i && !polled && !serial_enable_output_n_i;
        strobe_bad = almost_full_bus_strobe_i && !strobe_ok;
        dir_own_next = dir_own_reg;
        dir_sect_next = dir_sect_reg;
        if (strobe_ok) begin
            dir_own_next = dev_match;
            dir_sect_next = write_queue_address_bus_i[`WPF_SECT_BIT];
        end
        if (polled) begin
            dir_own_next = 1'h0;
        end
        bus_next = `WPF_BUS_IDLE;
        bus_oe_next = 1'h0;
        sync_next = 1'h0;
        token_next = 1'h0;
        if (polled) begin
            if (seq_state_next == WPF_POLL_SECT1) begin
                bus_next = sect1_n;
                bus_oe_next = 1'h1;
                sync_next = 1'h1;
            end else if (seq_state_next == WPF_POLL_SECT2) begin
                bus_next = sect2_n;
                bus_oe_next = 1'h1;
                token_next = 1'h1;
            end
        end else if (dir_own_next) begin
            // The latched sector keeps tracking live flags until the next strobe.
            bus_next = dir_sect_next ? sect2_n : sect1_n;
            bus_oe_next = 1'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dir_own_reg <= 1'h0;
            dir_sect_reg <= 1'h0;
            bus_reg <= `WPF_BUS_IDLE;
            bus_oe_reg <= 1'h0;
            sync_reg <= 1'h0;
            token_reg <= 1'h0;
        end else begin
            dir_own_reg <= dir_own_next;
            dir_sect_reg <= dir_sect_next;
            bus_reg <= bus_next;
            bus_oe_reg <= bus_oe_next;
            sync_reg <= sync_next;
            token_reg <= token_next;
        end
    end

    assign almost_full_flag_bus_n_o = bus_reg;
    assign almost_full_flag_bus_oe_o = bus_oe_reg;
    assign almost_full_bus_sync_o = sync_reg;
    assign almost_full_token_out_o = token_reg;

    // Interrupt status, mask and register read port.
    logic [`WPF_IRQ_W-1:0] irq_stat_reg;
    logic [`WPF_IRQ_W-1:0] irq_stat_next;
    logic [`WPF_IRQ_W-1:0] irq_mask_reg;
    logic [`WPF_IRQ_W-1:0] irq_mask_next;
    logic [`WPF_IRQ_W-1:0] irq_set;
    logic [`WPF_IRQ_W-1:0] irq_clr;
    logic irq_reg;
    logic irq_next;
    logic ff_prev_reg;
    logic ff_prev_next;
    logic [`WPF_REG_DW-1:0] rdata_reg;
    logic [`WPF_REG_DW-1:0] rdata_next;
    logic [`WPF_REG_DW-1:0] status_word;

    always_comb begin
        ff_prev_next = full_flag_n_o;
        irq_set = '0;
        // The owned queue just turned full: writes on the shared line stop here.
        irq_set[`WPF_IRQ_FULL] = full_flag_oe_o && ff_prev_reg && !full_flag_n_o;
        irq_set[`WPF_IRQ_LOOP] = sync_next;
        irq_set[`WPF_IRQ_STRB] = strobe_bad;
        irq_clr = '0;
        if (reg_wr_i && (reg_addr_i == `WPF_OFS_IRQ_STAT)) begin
            irq_clr = reg_wdata_i[`WPF_IRQ_W-1:0];
        end
        // A new event wins over a clear written in the same cycle.
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
        irq_mask_next = irq_mask_reg;
        if (reg_wr_i && (reg_addr_i == `WPF_OFS_IRQ_MASK)) begin
            irq_mask_next = reg_wdata_i[`WPF_IRQ_W-1:0];
        end
        irq_next = |(irq_stat_next & irq_mask_next);

        status_word = '0;
        status_word[`WPF_ST_MODE] = polled;
        status_word[`WPF_ST_ID_MSB:`WPF_ST_ID_LSB] = id_reg;
        status_word[`WPF_ST_MASTER] = master_reg;
        status_word[`WPF_ST_QUEUE_MSB:`WPF_ST_QUEUE_LSB] = ff_queue;
        status_word[`WPF_ST_FF_OWN] = full_flag_oe_o;
        status_word[`WPF_ST_BUS_OE] = bus_oe_reg;
        status_word[`WPF_ST_SEQ_MSB:`WPF_ST_SEQ_LSB] = seq_state;
        status_word[`WPF_ST_SECT] = dir_sect_reg;

        rdata_next = `WPF_RDATA_RST;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `WPF_OFS_STATUS: rdata_next = status_word;
                `WPF_OFS_IRQ_STAT: rdata_next[`WPF_IRQ_W-1:0] = irq_stat_reg;
                `WPF_OFS_IRQ_MASK: rdata_next[`WPF_IRQ_W-1:0] = irq_mask_reg;
                default: rdata_next = `WPF_RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat_reg <= `WPF_IRQ_RST;
            irq_mask_reg <= `WPF_IRQ_RST;
            irq_reg <= 1'h0;
            ff_prev_reg <= 1'h0;
            rdata_reg <= `WPF_RDATA_RST;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
            ff_prev_reg <= ff_prev_next;
            rdata_reg <= rdata_next;
        end
    end

    assign irq_o = irq_reg;
    assign reg_rdata_o = rdata_reg;

endmodule : wpf_top

`default_nettype wire

//--- wpf_top_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "wpf_map.svh"

module wpf_top_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`WPF_WADDR_W-1:0] write_queue_address_bus_i,
    input wire logic write_address_enable_i,
    input wire logic [`WPF_NUM_QUEUES-1:0] queue_full_i,
    input wire logic [`WPF_NUM_QUEUES-1:0] queue_almost_full_i,
    input wire logic flag_mode_select_i,
    input wire logic [`WPF_ID_W-1:0] device_identity_pins_i,
    input wire logic almost_full_bus_strobe_i,
    input wire logic serial_enable_output_n_i,
    input wire logic almost_full_token_in_i,
    input wire logic full_flag_n_o,
    input wire logic full_flag_oe_o,
    input wire logic [`WPF_SECT_W-1:0] almost_full_flag_bus_n_o,
    input wire logic almost_full_flag_bus_oe_o,
    input wire logic almost_full_bus_sync_o,
    input wire logic almost_full_token_out_o
);
    wire logic [`WPF_WADDR_W-1:0] a = write_queue_address_bus_i;
    wire logic hit = (a[`WPF_DEV_MSB:`WPF_DEV_LSB] == device_identity_pins_i);
    wire logic pm = flag_mode_select_i;
    wire logic sy = almost_full_bus_sync_o;
    wire logic tk = almost_full_token_out_o;
    wire logic sel = write_address_enable_i;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_ff_own;
        sel && hit |=> full_flag_oe_o;
    endproperty
    a_ff_own: assert property (p_ff_own) else $error("full flag not driven after own select");

    property p_ff_val;
        sel && hit && !a[4] |=> full_flag_n_o == ~$past(queue_full_i[a[3:0]]);
    endproperty
    a_ff_val: assert property (p_ff_val) else $error("full flag shows wrong queue");

    property p_ff_other;
        sel && !hit |=> !full_flag_oe_o;
    endproperty
    a_ff_other: assert property (p_ff_other) else $error("full flag driven for other device");

    property p_ff_keep;
        !sel |=> $stable(full_flag_oe_o);
    endproperty
    a_ff_keep: assert property (p_ff_keep) else $error("full flag ownership moved without select");

    property p_sect2;
        sy |=> !sy && tk && almost_full_flag_bus_oe_o;
    endproperty
    a_sect2: assert property (p_sect2) else $error("second sector did not follow first");

    property p_tok;
        tk |-> !sy && $past(sy);
    endproperty
    a_tok: assert property (p_tok) else $error("token out outside second sector");

    property p_load;
        pm && almost_full_token_in_i && !sy |=> sy && almost_full_flag_bus_n_o == ~$past(queue_almost_full_i[7:0]);
    endproperty
    a_load: assert property (p_load) else $error("token did not load first sector");

    property p_idle;
        pm && $past(rst_n_i) && !sy && !almost_full_token_in_i |=> !sy && !almost_full_flag_bus_oe_o;
    endproperty
    a_idle: assert property (p_idle) else $error("flag bus driven without token");

    property p_dir;
        !pm && almost_full_bus_strobe_i && !serial_enable_output_n_i && hit |=> almost_full_flag_bus_oe_o
            && almost_full_flag_bus_n_o == ~$past(a[3] ? queue_almost_full_i[15:8] : queue_almost_full_i[7:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("strobe did not latch addressed sector");

    property p_dir_quiet;
        !pm |-> !sy && !tk;
    endproperty
    a_dir_quiet: assert property (p_dir_quiet) else $error("sync or token in direct mode");

    c_sel: cover property (sel && hit);
    c_loop: cover property (sy ##1 tk ##1 sy);
    c_strobe: cover property (!pm && almost_full_bus_strobe_i && hit);
endmodule : wpf_top_props

`default_nettype wire

//--- write_port_flag_bus_logic_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "wpf_map.svh"

module write_port_flag_bus_logic_bench;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [7:0] wa = 8'h00;
    logic [7:0] ra = 8'h00;
    logic [15:0] qf = 16'h0000;
    logic [15:0] qaf = 16'h0000;
    logic [31:0] rwd = 32'h0000_0000;
    logic [2:0] idp = 3'h1;
    logic [3:0] dly = 4'h0;
    logic wen = 1'h0, fm = 1'h0, mst = 1'h1, almost_full_bus_strobe = 1'h0, sen_n = 1'h1, rwr = 1'h0, rrd = 1'h0;
    logic tin, ffn, ffoe, busoe, sync, tok, irq;
    logic [7:0] bus;
    logic [31:0] rdata;
    int n_mismatch = 0;
    int total_checks = 0;

    always #12.5 clk_i = ~clk_i;

    wpf_top i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .write_queue_address_bus_i(wa), .write_address_enable_i(wen),
        .queue_full_i(qf), .queue_almost_full_i(qaf), .flag_mode_select_i(fm), .device_identity_pins_i(idp),
        .master_device_i(mst), .almost_full_bus_strobe_i(almost_full_bus_strobe), .serial_enable_output_n_i(sen_n),
        .almost_full_token_in_i(tin), .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd),
        .full_flag_n_o(ffn), .full_flag_oe_o(ffoe), .almost_full_flag_bus_n_o(bus),
        .almost_full_flag_bus_oe_o(busoe), .almost_full_bus_sync_o(sync), .almost_full_token_out_o(tok),
        .reg_rdata_o(rdata), .irq_o(irq)
    );

    wpf_token_peer i_peer (.clk_i(clk_i), .rst_n_i(rst_n_i), .delay_i(dly), .token_i(tok), .token_o(tin));

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic do_reset(input logic m, input logic ma, input logic [3:0] d);
        rst_n_i <= 1'h0;
        fm <= m;
        mst <= ma;
        dly <= d;
        tick(6);
        rst_n_i <= 1'h1;
        tick(1);
    endtask : do_reset

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        ra <= a;
        rrd <= 1'h1;
        tick(1);
        rrd <= 1'h0;
        chk(rdata & m, exp, "register read");
        // Letting an edge pass keeps a following read from raising the strobe in this same step.
        tick(1);
        chk(rdata, 32'h0, "read data after its cycle");
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ra <= a;
        rwd <= d;
        rwr <= 1'h1;
        tick(1);
        rwr <= 1'h0;
    endtask : wr

    task automatic sel(input logic [7:0] a);
        wa <= a;
        wen <= 1'h1;
        tick(1);
        wen <= 1'h0;
    endtask : sel

    task automatic strb(input logic [7:0] a);
        wa <= a;
        almost_full_bus_strobe <= 1'h1;
        tick(1);
        almost_full_bus_strobe <= 1'h0;
        tick(1);
    endtask : strb

    task automatic t_reset;
        do_reset(1'h0, 1'h1, 4'h0);
        chk(ffoe, 1'h0, "full flag oe at reset");
        chk({busoe, bus}, 9'h0ff, "flag bus at reset");
        rd(`WPF_OFS_STATUS, 32'h0000_0012, 32'h0000_0fff);
        rd(`WPF_OFS_IRQ_STAT, 32'h0, 32'hffff_ffff);
        rd(`WPF_OFS_IRQ_MASK, 32'h0, 32'hffff_ffff);
        rd(8'hc0, 32'h0, 32'hffff_ffff);
        $display("test reset done");
    endtask : t_reset

    task automatic t_full;
        sel({idp, 5'h03});
        chk({ffoe, ffn}, 2'h3, "own queue selected");
        qf <= 16'h0008;
        tick(1);
        chk(ffn, 1'h0, "full flag follows queue");
        tick(1);
        rd(`WPF_OFS_IRQ_STAT, 32'h1, 32'h7);
        wr(`WPF_OFS_IRQ_MASK, 32'h1);
        tick(2);
        chk(irq, 1'h1, "irq on unmasked status");
        wr(`WPF_OFS_IRQ_STAT, 32'h1);
        tick(2);
        chk(irq, 1'h0, "irq after clear");
        wa <= {idp, 5'h04};
        wen <= 1'h1;
        tick(1);
        chk(ffn, 1'h1, "back to back select first");
        wa <= {idp, 5'h13};
        tick(1);
        chk(ffn, 1'h0, "queue above range reads full");
        sel({idp + 3'h1, 5'h03});
        chk(ffoe, 1'h0, "other device selected");
        // The owned flag fell on the out-of-range queue, so the full event is pending and must be cleared.
        rd(`WPF_OFS_IRQ_STAT, 32'h1, 32'h7);
        wr(`WPF_OFS_IRQ_STAT, 32'h1);
        $display("test full flag done");
    endtask : t_full

    task automatic t_direct;
        strb({idp, 5'h08});
        chk(busoe, 1'h0, "strobe before programming done");
        rd(`WPF_OFS_IRQ_STAT, 32'h4, 32'h7);
        wr(`WPF_OFS_IRQ_STAT, 32'h4);
        sen_n <= 1'h0;
        qaf <= 16'h12c4;
        strb({idp, 5'h08});
        chk({busoe, bus}, {1'h1, ~8'h12}, "direct upper sector");
        strb({idp, 5'h00});
        chk({busoe, bus}, {1'h1, ~8'hc4}, "direct lower sector");
        strb({idp + 3'h1, 5'h00});
        chk(busoe, 1'h0, "direct strobe other device");
        $display("test direct done");
    endtask : t_direct

    task automatic t_polled;
        int i;
        do_reset(1'h1, 1'h1, 4'h0);
        for (i = 0; i < 20 && sync !== 1'h1; i++) begin
            tick(1);
        end
        chk({busoe, bus}, {1'h1, ~qaf[7:0]}, "first sector");
        tick(1);
        chk({sync, tok, bus}, {2'h1, ~qaf[15:8]}, "second sector");
        tick(1);
        chk(sync, 1'h1, "first sector again");
        rd(`WPF_OFS_IRQ_STAT, 32'h2, 32'h2);
        strb({idp, 5'h00});
        rd(`WPF_OFS_IRQ_STAT, 32'h4, 32'h4);
        $display("test polled done");
    endtask : t_polled

    task automatic t_chain(input logic [3:0] d);
        int i;
        int n;
        do_reset(1'h1, 1'h1, d);
        for (i = 0; i < 40 && tok !== 1'h1; i++) begin
            tick(1);
        end
        n = 0;
        tick(1);
        chk(busoe, 1'h0, "bus released awaiting token");
        for (n = 1; n < 40 && sync !== 1'h1; n++) begin
            tick(1);
        end
        chk(32'(n), 32'(d) + 32'h1, "token to first sector gap");
        $display("test chain done");
    endtask : t_chain

    task automatic t_slave;
        do_reset(1'h1, 1'h0, 4'h0);
        tick(8);
        chk({busoe, sync}, 2'h0, "slave waits for token");
        $display("test slave done");
    endtask : t_slave

    initial begin
        t_reset();
        t_full();
        t_direct();
        t_polled();
        t_chain(4'h2);
        t_chain(4'h5);
        t_slave();
        summarize();
    end

    initial begin
        #200000;
        n_mismatch++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
endmodule : write_port_flag_bus_logic_bench

bind wpf_top wpf_top_props i_props (
    .clk_i, .rst_n_i, .write_queue_address_bus_i, .write_address_enable_i, .queue_full_i,
    .queue_almost_full_i, .flag_mode_select_i, .device_identity_pins_i, .almost_full_bus_strobe_i,
    .serial_enable_output_n_i, .almost_full_token_in_i, .full_flag_n_o, .full_flag_oe_o,
    .almost_full_flag_bus_n_o, .almost_full_flag_bus_oe_o, .almost_full_bus_sync_o, .almost_full_token_out_o
);

`default_nettype wire
